// ===== core/lft_map.vh
/*
 * constants for the laser firing timestamp logic: time units, block layout,
 * schedule step spacing, packet field sizes.
 * assumes inclusion by bare name from the core modules; definitions only.
 */
// Contract
// - packet time is date plus seconds plus microseconds
// - packet carries 6-byte date-time, 4-byte microseconds; record holds 5-byte (40-bit) seconds
// - no satellite packets while ptp source selected
// - every packet body holds six blocks
// - round fills one block, two when dual
// - single: block 6 ends 42.58 early, 55.56 steps
// - dual: pairs share end, 55.56 per pair
// - channel fire time is block start plus offset
// - 32 paired steps, -54.668 to -3.62 us
// - ptp slave locks automatically, no setup
// - locked: timestamps follow master time
// - no master: count from invalid past time
// - master lost: keep counting on internal clock
`ifndef LFT_MAP_VH
`define LFT_MAP_VH

// ==========================================
// time units (ns, cycles per us, us limit), step and channel counts
`define LFT_CLK_NS 8
`define LFT_US_CYC 125
`define LFT_US_MAX 32'h000F423F
`define LFT_BLK6_END_NS 42580
`define LFT_ROUND_NS 55560
`define LFT_STEP1_NS 54668
`define LFT_STEP_A_NS 1968
`define LFT_STEP_B_NS 1304
`define LFT_STEP_SPLIT 17
`define LFT_STEPS 32
`define LFT_CHANNELS 64

// ==========================================
// packet layout
`define LFT_BLOCKS 6
`define LFT_DT_BYTES 6
`define LFT_TS_BYTES 4
`define LFT_INVALID_SEC 40'h0000000000

`endif

// ===== core/lft_fifo.v
/*
 * small synchronous fifo for packet time records.
 * assumes one clock, reader may stall at will.
 */
`timescale 1ns/10ps
module lft_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // write side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // read side
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire do_wr;
    wire do_rd;

    // ==========================================
    // flags
    assign in_ready = (cnt_r != DEPTH);
    assign do_rd = (cnt_r != 0) && (!out_valid || out_ready);
    assign do_wr = in_valid && in_ready;

    // storage writes, no reset needed on data
    always @(posedge clk)
    begin
        if (do_wr)
            mem[wp_r] <= in_data;
    end

    // pointers, count and registered read port
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end
        else
        begin
            if (do_wr)
                wp_r <= wp_r + 1'b1;
            if (do_rd)
            begin
                rp_r <= rp_r + 1'b1;
                out_data <= mem[rp_r];
                out_valid <= 1'b1;
            end
            else if (out_ready)
                out_valid <= 1'b0;
            cnt_r <= cnt_r + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        end
    end
endmodule

// ===== core/lft_offset_rom.v
/*
 * per-channel firing offset lookup, registered output.
 * assumes channel index 1..64; offsets are magnitudes in ns before block start.
 */
`timescale 1ns/10ps
`include "lft_map.vh"
module lft_offset_rom (
    // clock and reset
    input wire clk,
    input wire resetn,
    // lookup
    input wire [6:0] chan,
    output reg [5:0] step,
    output reg [15:0] offset_ns
);
    // step number per channel, constant table
    function [5:0] chan_step;
        input [6:0] c;
        begin
            case (c)
                7'h0C, 7'h28: chan_step = 6'h01;
                7'h12, 7'h26: chan_step = 6'h02;
                7'h0B, 7'h1A: chan_step = 6'h03;
                7'h11, 7'h20: chan_step = 6'h04;
                7'h08, 7'h17: chan_step = 6'h05;
                7'h0E, 7'h1D: chan_step = 6'h06;
                7'h14, 7'h23: chan_step = 6'h07;
                7'h0D, 7'h1C: chan_step = 6'h08;
                7'h13, 7'h22: chan_step = 6'h09;
                7'h0A, 7'h19: chan_step = 6'h0A;
                7'h10, 7'h1F: chan_step = 6'h0B;
                7'h16, 7'h25: chan_step = 6'h0C;
                7'h0F, 7'h1E: chan_step = 6'h0D;
                7'h15, 7'h24: chan_step = 6'h0E;
                7'h1B, 7'h2A: chan_step = 6'h0F;
                7'h18, 7'h21: chan_step = 6'h10;
                7'h01, 7'h2C: chan_step = 6'h11;
                7'h02, 7'h2E: chan_step = 6'h12;
                7'h03, 7'h34: chan_step = 6'h13;
                7'h04, 7'h32: chan_step = 6'h14;
                7'h05, 7'h30: chan_step = 6'h15;
                7'h06, 7'h36: chan_step = 6'h16;
                7'h29, 7'h3A: chan_step = 6'h17;
                7'h2F, 7'h3E: chan_step = 6'h18;
                7'h35, 7'h40: chan_step = 6'h19;
                7'h07, 7'h38: chan_step = 6'h1A;
                7'h2B, 7'h3B: chan_step = 6'h1B;
                7'h31, 7'h3F: chan_step = 6'h1C;
                7'h09, 7'h37: chan_step = 6'h1D;
                7'h27, 7'h39: chan_step = 6'h1E;
                7'h2D, 7'h3C: chan_step = 6'h1F;
                7'h33, 7'h3D: chan_step = 6'h20;
                default: chan_step = 6'h00;
            endcase
        end
    endfunction

    // offset magnitude from step: two spacings joined at step 17
    function [15:0] step_off;
        input [5:0] s;
        reg [31:0] a;
        begin
            a = 32'h00000000;
            if (s == 6'h00)
                a = 32'h00000000;
            else if (s <= `LFT_STEP_SPLIT)
                a = `LFT_STEP1_NS - `LFT_STEP_A_NS * (s - 1);
            else
                a = `LFT_STEP1_NS - `LFT_STEP_A_NS * (`LFT_STEP_SPLIT - 1)
                    - `LFT_STEP_B_NS * (s - `LFT_STEP_SPLIT);
            // offsets stay below 64k ns, so the upper half is always zero
            step_off = a[15:0];
        end
    endfunction

    // registered lookup
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            step <= 6'h00;
            offset_ns <= 16'h0000;
        end
        else
        begin
            step <= chan_step(chan);
            offset_ns <= step_off(chan_step(chan));
        end
    end
endmodule

// ===== core/lft_top.v
/*
 * laser firing timestamp logic: keeps absolute time (seconds + us), follows a
 * ptp master when selected, stamps packets, gives block end and channel fire times.
 * assumes ptp time and pps-like pins arrive asynchronously; packet request from
 * same-clock logic; the consumer drains the packet record fifo.
 */
`timescale 1ns/10ps
`include "lft_map.vh"
module lft_top #(
    parameter SEC_W = 40,
    parameter FIFO_DEPTH = 8
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // mode selects (same clock domain)
    input wire ptp_sel,
    input wire dual_mode,
    // ptp master time, asynchronous
    input wire ptp_lock,
    input wire ptp_load,
    input wire [SEC_W-1:0] ptp_sec,
    input wire [19:0] ptp_us,
    // packet request
    input wire pkt_req,
    output reg pkt_req_ready,
    // packet time record out
    output reg rec_valid,
    input wire rec_ready,
    output reg [79:0] rec_data,
    // satellite packet permit
    output reg sat_pkt_en,
    // block end time query
    input wire [2:0] blk_num,
    output reg [31:0] blk_end_ns,
    output reg [2:0] blk_round,
    // channel fire offset query
    input wire [6:0] chan_num,
    output reg [31:0] fire_ns,
    output reg [5:0] fire_step,
    // status
    output reg locked,
    output reg time_valid
);
    localparam ST_FREE = 3'h1;
    localparam ST_LOCK = 3'h2;
    localparam ST_HOLD = 3'h4;
    localparam REC_W = SEC_W + 32 + 8;

    reg [2:0] st_r;
    reg [2:0] st_nxt;
    reg [SEC_W-1:0] sec_r;
    reg [19:0] us_r;
    reg [6:0] cyc_r;
    reg lock_s1, lock_s2, load_s1, load_s2, load_s3;
    reg [SEC_W-1:0] psec_s1, psec_s2;
    reg [19:0] pus_s1, pus_s2;
    reg seen_r;
    wire us_tick;
    wire load_edge;
    wire fin_ready;
    wire fo_valid;
    wire [REC_W-1:0] fo_data;
    wire fo_ready;
    wire [5:0] rom_step;
    wire [15:0] rom_off;

    // ==========================================
    // synchronisers; ptp words settle before load edge
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            load_s1 <= 1'b0;
            load_s2 <= 1'b0;
            load_s3 <= 1'b0;
            psec_s1 <= {SEC_W{1'b0}};
            psec_s2 <= {SEC_W{1'b0}};
            pus_s1 <= 20'h00000;
            pus_s2 <= 20'h00000;
        end
        else
        begin
            lock_s1 <= ptp_lock;
            lock_s2 <= lock_s1;
            load_s1 <= ptp_load;
            load_s2 <= load_s1;
            load_s3 <= load_s2;
            psec_s1 <= ptp_sec;
            psec_s2 <= psec_s1;
            pus_s1 <= ptp_us;
            pus_s2 <= pus_s1;
        end
    end

    assign load_edge = load_s2 & ~load_s3;

    // ==========================================
    // ptp follower state
    always @*
    begin
        st_nxt = st_r;
        case (st_r)
            ST_FREE: if (ptp_sel && lock_s2) st_nxt = ST_LOCK;
            ST_LOCK: if (!ptp_sel) st_nxt = ST_FREE;
                     else if (!lock_s2) st_nxt = ST_HOLD;
            ST_HOLD: if (!ptp_sel) st_nxt = ST_FREE;
                     else if (lock_s2) st_nxt = ST_LOCK;
            default: st_nxt = ST_FREE;
        endcase
    end

    // microsecond divider enable
    assign us_tick = (cyc_r == `LFT_US_CYC - 1);

    // time counter; master load overrides free running
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= ST_FREE;
            cyc_r <= 7'h00;
            sec_r <= `LFT_INVALID_SEC;
            us_r <= 20'h00000;
            seen_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_r == ST_LOCK && load_edge)
            begin
                sec_r <= psec_s2;
                us_r <= pus_s2;
                cyc_r <= 7'h00;
                seen_r <= 1'b1;
            end
            else
            begin
                cyc_r <= us_tick ? 7'h00 : cyc_r + 7'h01;
                if (us_tick)
                begin
                    // hold and free both keep counting on the local clock
                    if (us_r >= `LFT_US_MAX)
                    begin
                        us_r <= 20'h00000;
                        sec_r <= sec_r + 1'b1;
                    end
                    else
                        us_r <= us_r + 20'h00001;
                end
            end
        end
    end

    // ==========================================
    // output stage takes a record when empty or drained; valid and ready then meet at the port
    assign fo_ready = !rec_valid || rec_ready;

    // packet record: seconds (date+time) and us field, plus block count
    lft_fifo #(
        .WIDTH(REC_W),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(pkt_req),
        .in_ready(fin_ready),
        .in_data({sec_r, 12'h000, us_r, 8'h06}),
        .out_valid(fo_valid),
        .out_ready(fo_ready),
        .out_data(fo_data)
    );

    // channel offset table
    lft_offset_rom u_rom (
        .clk(clk),
        .resetn(resetn),
        .chan(chan_num),
        .step(rom_step),
        .offset_ns(rom_off)
    );

    // round index of a block: single one per block, dual one per pair
    function [2:0] blk_rounds;
        input [2:0] b;
        input d;
        begin
            if (b == 3'h0 || b > `LFT_BLOCKS)
                blk_rounds = 3'h0;
            else if (d)
                blk_rounds = (3'h6 - b) >> 1;
            else
                blk_rounds = 3'h6 - b;
        end
    endfunction

    // end time before packet time, ns
    function [31:0] end_ns;
        input [2:0] r;
        begin
            end_ns = `LFT_BLK6_END_NS + `LFT_ROUND_NS * r;
        end
    endfunction

    // ==========================================
    // registered outputs
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pkt_req_ready <= 1'b0;
            rec_valid <= 1'b0;
            rec_data <= 80'h0;
            sat_pkt_en <= 1'b1;
            blk_end_ns <= 32'h00000000;
            blk_round <= 3'h0;
            fire_ns <= 32'h00000000;
            fire_step <= 6'h00;
            locked <= 1'b0;
            time_valid <= 1'b0;
        end
        else
        begin
            pkt_req_ready <= fin_ready;
            // a lagging copy of the fifo port would drop records, so this is a real stage
            if (fo_valid && fo_ready)
            begin
                rec_valid <= 1'b1;
                rec_data <= fo_data[REC_W-1:0];
            end
            else if (rec_ready)
                rec_valid <= 1'b0;
            sat_pkt_en <= ~ptp_sel;
            blk_round <= blk_rounds(blk_num, dual_mode);
            blk_end_ns <= end_ns(blk_rounds(blk_num, dual_mode));
            // channel fires offset before block start, in ns below start
            fire_ns <= {16'h0000, rom_off};
            fire_step <= rom_step;
            locked <= (st_r == ST_LOCK);
            time_valid <= seen_r;
        end
    end
endmodule

// ===== verification/lft_host_model.sv
/*
 * host receiver and ptp master model for lft_top.
 * assumes the block's clock; the bench drives ptp_lock and calls set_time.
 */
`timescale 1ns/10ps
module lft_host_model (
    // clock and reset
    input wire clk,
    input wire resetn,
    // record stream
    input wire rec_valid,
    input wire [79:0] rec_data,
    output reg rec_ready,
    input wire stall,
    // master time
    output reg ptp_lock,
    output reg ptp_load,
    output reg [39:0] ptp_sec,
    output reg [19:0] ptp_us
);
    logic [79:0] got[$];

    initial
    begin
        rec_ready = 1'b0;
        ptp_lock = 1'b0;
        ptp_load = 1'b0;
        ptp_sec = 40'h0000000000;
        ptp_us = 20'h00000;
    end

    // ==========================================
    // drain every other cycle to keep back-pressure on the output stage
    always @(posedge clk)
    begin
        if (rec_valid && rec_ready)
            got.push_back(rec_data);
        rec_ready <= #1 !stall && !rec_ready && resetn;
    end

    // ==========================================
    // words held 4 cycles each side of the load edge, then garbled
    task set_time(input [39:0] s, input [19:0] u);
    begin
        ptp_sec = s;
        ptp_us = u;
        repeat (4) @(posedge clk);
        #1 ptp_load = 1'b1;
        repeat (4) @(posedge clk);
        #1 ptp_load = 1'b0;
        ptp_sec = ~s;
        ptp_us = ~u;
    end
    endtask
endmodule

// ===== verification/lft_top_asserts.sv
/*
 * concurrent checks on the lft_top ports.
 * assumes one clock domain, bound into every lft_top instance.
 */
`timescale 1ns/10ps
module lft_top_asserts (
    // clock and reset
    input wire clk,
    input wire resetn,
    // inputs
    input wire ptp_sel,
    input wire dual_mode,
    input wire ptp_lock,
    input wire [2:0] blk_num,
    input wire [6:0] chan_num,
    // outputs
    input wire rec_valid,
    input wire [79:0] rec_data,
    input wire sat_pkt_en,
    input wire [31:0] blk_end_ns,
    input wire [2:0] blk_round,
    input wire [31:0] fire_ns,
    input wire [5:0] fire_step,
    input wire locked,
    input wire time_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ==========================================
    // offset magnitude from schedule step, two spacings
    function [31:0] f_ns(input [5:0] s);
        f_ns = s <= 6'h11 ? 32'h0000D58C - 32'h000007B0 * (s - 6'h01) : 32'h00005A8C - 32'h00000518 * (s - 6'h11);
    endfunction

    sequence s_blk_ok;
        blk_num >= 3'h1 && blk_num <= 3'h6;
    endsequence
    sequence s_chan_held;
        (chan_num >= 7'h01 && chan_num <= 7'h40) ##1 $stable(chan_num);
    endsequence
    sequence s_lock_req;
        (ptp_sel && ptp_lock) [*5];
    endsequence

    // ==========================================
    // sat permit checks take two samples so a reset release never trips them
    AST_SAT_OFF: assert property ((ptp_sel ##1 ptp_sel) |-> !sat_pkt_en) else $error("sat packets on");
    AST_SAT_ON: assert property ((!ptp_sel ##1 !ptp_sel) |-> sat_pkt_en) else $error("sat packets off");
    AST_RND_SINGLE: assert property ((blk_num >= 3'h1 && blk_num <= 3'h6 && !dual_mode) |=>
        blk_round == 3'h6 - $past(blk_num)) else $error("single round wrong");
    AST_RND_DUAL: assert property ((blk_num >= 3'h1 && blk_num <= 3'h6 && dual_mode) |=>
        blk_round == (3'h6 - $past(blk_num)) >> 1) else $error("dual round wrong");
    AST_BLK_END: assert property (s_blk_ok |=> blk_end_ns == 32'h0000A654 + 32'h0000D908 * blk_round)
        else $error("block end wrong");
    AST_FIRE_NS: assert property (fire_step != 6'h00 |-> fire_ns == f_ns(fire_step)) else $error("offset wrong");
    AST_FIRE_STEP: assert property (s_chan_held |=> fire_step >= 6'h01 && fire_step <= 6'h20)
        else $error("step out of range");
    AST_REC_FIELDS: assert property (rec_valid |-> rec_data[7:0] == 8'h06 && rec_data[39:28] == 12'h000)
        else $error("record layout wrong");
    AST_US_WRAP: assert property (rec_valid |-> rec_data[27:8] <= 20'hF423F) else $error("us not wrapped");
    AST_LOCK: assert property (s_lock_req |-> locked) else $error("no lock");
    AST_NO_MASTER: assert property ((!locked && !time_valid) |=> !time_valid) else $error("valid unlocked");
    AST_KEEP_VALID: assert property (time_valid |=> time_valid) else $error("time lost");
endmodule

bind lft_top lft_top_asserts i_lft_top_asserts (.clk, .resetn, .ptp_sel, .dual_mode, .ptp_lock, .blk_num,
    .chan_num, .rec_valid, .rec_data, .sat_pkt_en, .blk_end_ns, .blk_round, .fire_ns, .fire_step, .locked,
    .time_valid);

// ===== verification/lft_top_tb.sv
/*
 * self-checking bench for lft_top with the host and master model.
 * assumes 125 MHz clock; inputs change 1 ns after the rising edge.
 */
`timescale 1ns/10ps
module lft_top_tb;
    reg clk, resetn, ptp_sel, dual_mode, pkt_req, stall;
    reg [2:0] blk_num;
    reg [6:0] chan_num;
    wire ptp_lock, ptp_load, pkt_req_ready, rec_valid, rec_ready, sat_pkt_en, locked, time_valid;
    wire [39:0] ptp_sec;
    wire [19:0] ptp_us;
    wire [79:0] rec_data;
    wire [31:0] blk_end_ns, fire_ns;
    wire [2:0] blk_round;
    wire [5:0] fire_step;
    integer n_fail, n_compared, seed, i, k;
    reg [39:0] s0;
    reg [19:0] p;
    reg [79:0] r;

    lft_top i_lft_top (.clk, .resetn, .ptp_sel, .dual_mode, .ptp_lock, .ptp_load, .ptp_sec, .ptp_us, .pkt_req,
        .pkt_req_ready, .rec_valid, .rec_ready, .rec_data, .sat_pkt_en, .blk_num, .blk_end_ns, .blk_round,
        .chan_num, .fire_ns, .fire_step, .locked, .time_valid);
    lft_host_model i_lft_host_model (.clk, .resetn, .rec_valid, .rec_data, .rec_ready, .stall, .ptp_lock,
        .ptp_load, .ptp_sec, .ptp_us);

    // ==========================================
    // expectations
    function [2:0] e_rnd(input [2:0] b, input d);
        e_rnd = (b == 3'h0 || b == 3'h7) ? 3'h0 : d ? (3'h6 - b) >> 1 : 3'h6 - b;
    endfunction
    function [31:0] e_fire(input [5:0] s);
        e_fire = s <= 6'h11 ? 32'h0000D58C - 32'h000007B0 * (s - 6'h01) : 32'h00005A8C - 32'h00000518 * (s - 6'h11);
    endfunction
    // full firing schedule, channel to step, two channels per step
    function [5:0] step_of(input [6:0] c);
        case (c)
            7'h0C, 7'h28: step_of = 6'h01;
            7'h12, 7'h26: step_of = 6'h02;
            7'h0B, 7'h1A: step_of = 6'h03;
            7'h11, 7'h20: step_of = 6'h04;
            7'h08, 7'h17: step_of = 6'h05;
            7'h0E, 7'h1D: step_of = 6'h06;
            7'h14, 7'h23: step_of = 6'h07;
            7'h0D, 7'h1C: step_of = 6'h08;
            7'h13, 7'h22: step_of = 6'h09;
            7'h0A, 7'h19: step_of = 6'h0A;
            7'h10, 7'h1F: step_of = 6'h0B;
            7'h16, 7'h25: step_of = 6'h0C;
            7'h0F, 7'h1E: step_of = 6'h0D;
            7'h15, 7'h24: step_of = 6'h0E;
            7'h1B, 7'h2A: step_of = 6'h0F;
            7'h18, 7'h21: step_of = 6'h10;
            7'h01, 7'h2C: step_of = 6'h11;
            7'h02, 7'h2E: step_of = 6'h12;
            7'h03, 7'h34: step_of = 6'h13;
            7'h04, 7'h32: step_of = 6'h14;
            7'h05, 7'h30: step_of = 6'h15;
            7'h06, 7'h36: step_of = 6'h16;
            7'h29, 7'h3A: step_of = 6'h17;
            7'h2F, 7'h3E: step_of = 6'h18;
            7'h35, 7'h40: step_of = 6'h19;
            7'h07, 7'h38: step_of = 6'h1A;
            7'h2B, 7'h3B: step_of = 6'h1B;
            7'h31, 7'h3F: step_of = 6'h1C;
            7'h09, 7'h37: step_of = 6'h1D;
            7'h27, 7'h39: step_of = 6'h1E;
            7'h2D, 7'h3C: step_of = 6'h1F;
            7'h33, 7'h3D: step_of = 6'h20;
            default: step_of = 6'h00;
        endcase
    endfunction

    // ==========================================
    // shared tasks
    task check(input [79:0] got, input [79:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task close_out;
    begin
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    // one stamp request, then wait bounded for its record
    task stamp;
    begin
        pkt_req = 1'b1;
        @(posedge clk) #1 pkt_req = 1'b0;
        for (k = 0; k < 50 && i_lft_host_model.got.size() == 0; k = k + 1)
            @(posedge clk) #1;
        check(k < 50, 1'b1);
        r = i_lft_host_model.got.size() ? i_lft_host_model.got.pop_front() : 80'h0;
    end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // run needs about 6.5k cycles
    initial
    begin
        #300000 n_fail = n_fail + 1;
        close_out;
    end

    initial
    begin
        {n_fail, n_compared, seed} = {32'h0, 32'h0, 32'hD};
        {resetn, ptp_sel, dual_mode, pkt_req, stall, blk_num, chan_num} = 15'h0;
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        check(sat_pkt_en, 1'b1);
        stamp;
        check(r[79:40], 40'h0);
        // ptp chosen, no master: loads refused, time stays invalid
        ptp_sel = 1'b1;
        i_lft_host_model.set_time(40'h0000001234, 20'h00010);
        check(sat_pkt_en, 1'b0);
        check(time_valid, 1'b0);
        stamp;
        check(r[79:40], 40'h0);
        // master appears just before a second boundary
        i_lft_host_model.ptp_lock = 1'b1;
        repeat (6) @(posedge clk) #1;
        check(locked, 1'b1);
        s0 = {8'h00, $random(seed)};
        i_lft_host_model.set_time(s0, 20'hF422C);
        check(time_valid, 1'b1);
        stamp;
        check(r[79:40], s0);
        repeat (5000) @(posedge clk) #1;
        stamp;
        check(r[79:40], s0 + 40'h1);
        check(r[27:8] < 20'h00064, 1'b1);
        // master gone: count runs on
        p = r[27:8];
        i_lft_host_model.ptp_lock = 1'b0;
        repeat (1250) @(posedge clk) #1;
        stamp;
        check(r[27:8] - p >= 20'h0000A && r[27:8] - p <= 20'h0000B, 1'b1);
        check({time_valid, r[79:40]}, {1'b1, s0 + 40'h1});
        // every block in both modes, invalid numbers too
        for (i = 0; i < 16; i = i + 1)
        begin
            {dual_mode, blk_num} = i[3:0];
            @(posedge clk) #1;
            check(blk_round, e_rnd(i[2:0], i[3]));
            check(blk_end_ns, 32'h0000A654 + 32'h0000D908 * e_rnd(i[2:0], i[3]));
        end
        for (i = 0; i < 66; i = i + 1)
        begin
            chan_num = i[6:0];
            repeat (2) @(posedge clk) #1;
            if (step_of(i[6:0]) != 6'h00 || i == 0 || i > 64)
                check({fire_step, fire_ns}, {step_of(i[6:0]), step_of(i[6:0]) ? e_fire(step_of(i[6:0])) : 32'h0});
        end
        // host stalls: back-to-back requests overfill the fifo, then drain
        stall = 1'b1;
        repeat (3) @(posedge clk) #1;
        i_lft_host_model.got.delete();
        pkt_req = 1'b1;
        // at least 12 requests, so the fill edge has passed before ready is looked at
        repeat (12 + {$random(seed)} % 3) @(posedge clk) #1;
        pkt_req = 1'b0;
        check(pkt_req_ready, 1'b0);
        stall = 1'b0;
        repeat (60) @(posedge clk) #1;
        // eight fifo words plus its read register and the output stage
        check(i_lft_host_model.got.size() == 10, 1'b1);
        close_out;
    end
endmodule
